// *** shared/txir_pkg.sv ***
`default_nettype none
package txir_pkg;

  // Register offsets
  localparam logic [2:0] TXIR_FRAME_CONTROL_REG = 3'h0;
  localparam logic [2:0] TXIR_BASE_INTERVAL_RELOAD = 3'h1;
  localparam logic [2:0] TXIR_RANDOM_SEED_STATE = 3'h2;
  localparam logic [2:0] TXIR_FRAME_STEP_SETTING = 3'h3;
  localparam logic [2:0] TXIR_STATUS_REG = 3'h4;

  // Field positions of frame_control_reg
  localparam int TXIR_FCNT_LSB = 0;
  localparam int TXIR_INTERFRAME_POWERDOWN_BIT = 4;
  localparam int TXIR_ISCALE_BIT = 5;
  localparam int TXIR_SEND_BIT = 7;

  // Field positions of the status register
  localparam int TXIR_DONE_BIT = 0;
  localparam int TXIR_BUSY_BIT = 1;
  localparam int TXIR_FRNO_LSB = 3;

  // Reset values
  localparam logic [6:0] TXIR_LFSR_RESET = 7'h40;
  localparam logic [7:0] TXIR_BASE_RESET = 8'h00;
  localparam logic [5:0] TXIR_STEP_RESET = 6'h00;
  localparam logic [3:0] TXIR_FCNT_RESET = 4'h0;

  // Galois feedback mask for x^7+x^6+1
  localparam logic [6:0] TXIR_LFSR_TAPS = 7'h60;

  // Timing counts
  localparam int TXIR_MFO_DIV = 125;
  localparam logic [5:0] TXIR_INIT_SCALE = 6'd40;

  typedef enum logic [1:0] {
    TXIR_IDLE = 2'b00,
    TXIR_INIT = 2'b01,
    TXIR_FRAME = 2'b11,
    TXIR_GAP = 2'b10
  } txir_st_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } txir_bus_req_t;

  typedef struct packed {
    txir_st_t st;
    logic [6:0] divCnt;
    logic [7:0] baseCnt;
    logic [6:0] randCnt;
    logic [5:0] preCnt;
    logic [9:0] fnCnt;
    logic parallel;
    logic scaleAct;
    logic [4:0] frameNo;
    logic [3:0] frameCount;
    logic interframe_powerdown;
    logic iscale;
    logic [7:0] baseReload;
    logic [5:0] stepTime;
    logic [6:0] lfsr;
    logic doneFlag;
    logic [7:0] rdata;
  } txir_state_t;

endpackage
`default_nettype wire

// *** hdl/txir_randomizer.sv ***
// Summary of operation
// - Datagram is one to sixteen timed frames
// - Interframe power-down stops oscillator, VCO, PLL
// - Zero random: base and step count together
// - Interval expiry sends, completion wakes MCU
// - Scale bit makes initial random forty-fold
// - Gap is base plus random plus step
// - Eight-bit base count-down, zero gives none
// - All counters use MID_FREQ_OSC divided by 125
// - Random part only when LFSR nonzero
// - Seven-stage Galois LFSR, 127 values
// - LFSR starts at hex 40
// - Sample LFSR, then clock it once
// - Random time 1-127 ticks per count
// - Software reads and overwrites the LFSR
// - Step time times frame number, gaps only
// - Frame step is a 6-bit field
// - Frame count plus one gives frames
// - Base time in initial and every gap
// - Frame count is 4-bit control field
`timescale 1ns/1ps
`default_nettype none

module txir_randomizer #(
  parameter int MFO_DIV = txir_pkg::TXIR_MFO_DIV
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire txir_pkg::txir_bus_req_t busReq,
  output logic [7:0] readData,
  input wire logic midFreqOsc,
  input wire logic frameDone,
  output logic txRequest,
  output logic oscPowerDown,
  output logic wakeMcu
);
  import txir_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [6:0] lfsrStep(input logic [6:0] s);
    lfsrStep = s[0] ? ((s >> 1) ^ TXIR_LFSR_TAPS) : (s >> 1);
  endfunction

  function automatic logic [9:0] stepTimes(input logic [5:0] step,
                                           input logic [4:0] num);
    logic [10:0] p;
    p = 11'(step) * 11'(num);
    stepTimes = p[9:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  txir_state_t q;
  txir_state_t next_q;
  logic running;
  logic msTick;
  logic intervalDone;
  logic seedWr;
  logic sendWr;
  logic [7:0] readMux;

  assign running = (q.st == TXIR_INIT) || (q.st == TXIR_GAP);
  assign msTick = running && midFreqOsc &&
                  (q.divCnt == 7'(MFO_DIV - 1));
  assign intervalDone = running && (q.baseCnt == 8'h00) &&
                        (q.randCnt == 7'h00) && (q.fnCnt == 10'h000);
  assign seedWr = busReq.wr && (busReq.addr == TXIR_RANDOM_SEED_STATE);
  assign sendWr = busReq.wr && (busReq.addr == TXIR_FRAME_CONTROL_REG) &&
                  busReq.wdata[TXIR_SEND_BIT];

  always_comb begin
    readMux = 8'h00;
    unique case (busReq.addr)
      TXIR_FRAME_CONTROL_REG: begin
        readMux[TXIR_FCNT_LSB +: 4] = q.frameCount;
        readMux[TXIR_INTERFRAME_POWERDOWN_BIT] = q.interframe_powerdown;
        readMux[TXIR_ISCALE_BIT] = q.iscale;
        readMux[TXIR_SEND_BIT] = (q.st != TXIR_IDLE);
      end
      TXIR_BASE_INTERVAL_RELOAD: readMux = q.baseReload;
      TXIR_RANDOM_SEED_STATE: readMux = {1'b0, q.lfsr};
      TXIR_FRAME_STEP_SETTING: readMux = {2'b00, q.stepTime};
      TXIR_STATUS_REG: begin
        readMux[TXIR_DONE_BIT] = q.doneFlag;
        readMux[TXIR_BUSY_BIT] = (q.st != TXIR_IDLE);
        readMux[TXIR_FRNO_LSB +: 5] = q.frameNo;
      end
      default: readMux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_q = q;
    next_q.rdata = busReq.rd ? readMux : 8'h00;

    // Register writes
    if (busReq.wr) begin
      unique case (busReq.addr)
        TXIR_FRAME_CONTROL_REG: begin
          next_q.frameCount = busReq.wdata[TXIR_FCNT_LSB +: 4];
          next_q.interframe_powerdown = busReq.wdata[TXIR_INTERFRAME_POWERDOWN_BIT];
          next_q.iscale = busReq.wdata[TXIR_ISCALE_BIT];
        end
        TXIR_BASE_INTERVAL_RELOAD: next_q.baseReload = busReq.wdata;
        TXIR_RANDOM_SEED_STATE: next_q.lfsr = busReq.wdata[6:0];
        TXIR_FRAME_STEP_SETTING: next_q.stepTime = busReq.wdata[5:0];
        TXIR_STATUS_REG: begin
          if (busReq.wdata[TXIR_DONE_BIT]) begin
            next_q.doneFlag = 1'b0;
          end
        end
        default: next_q.doneFlag = q.doneFlag;
      endcase
    end

    // Millisecond divider
    if (!running) begin
      next_q.divCnt = 7'h00;
    end else if (midFreqOsc) begin
      next_q.divCnt = msTick ? 7'h00 : q.divCnt + 7'h01;
    end

    // Interval count-down
    if (msTick) begin
      if (q.baseCnt != 8'h00) begin
        next_q.baseCnt = q.baseCnt - 8'h01;
        if (q.parallel && (q.fnCnt != 10'h000)) begin
          next_q.fnCnt = q.fnCnt - 10'h001;
        end
      end else if (q.randCnt != 7'h00) begin
        if (q.preCnt == 6'h00) begin
          next_q.randCnt = q.randCnt - 7'h01;
          next_q.preCnt = q.scaleAct ? TXIR_INIT_SCALE - 6'h01 : 6'h00;
        end else begin
          next_q.preCnt = q.preCnt - 6'h01;
        end
      end else if (q.fnCnt != 10'h000) begin
        next_q.fnCnt = q.fnCnt - 10'h001;
      end
    end

    // Datagram sequencer
    unique case (q.st)
      TXIR_IDLE: begin
        if (sendWr) begin
          next_q.st = TXIR_INIT;
          next_q.frameNo = 5'h00;
          next_q.baseCnt = q.baseReload;
          next_q.randCnt = q.lfsr;
          next_q.parallel = (q.lfsr == 7'h00);
          next_q.scaleAct = busReq.wdata[TXIR_ISCALE_BIT];
          next_q.preCnt = busReq.wdata[TXIR_ISCALE_BIT] ?
                          TXIR_INIT_SCALE - 6'h01 : 6'h00;
          next_q.fnCnt = 10'h000;
        end
      end
      TXIR_INIT, TXIR_GAP: begin
        if (intervalDone) begin
          next_q.st = TXIR_FRAME;
          next_q.frameNo = q.frameNo + 5'h01;
          if (!seedWr) begin
            next_q.lfsr = lfsrStep(q.lfsr);
          end
        end
      end
      TXIR_FRAME: begin
        if (frameDone) begin
          if (q.frameNo == {1'b0, q.frameCount} + 5'h01) begin
            next_q.st = TXIR_IDLE;
            next_q.doneFlag = 1'b1;
          end else begin
            next_q.st = TXIR_GAP;
            next_q.baseCnt = q.baseReload;
            next_q.randCnt = q.lfsr;
            next_q.parallel = (q.lfsr == 7'h00);
            next_q.scaleAct = 1'b0;
            next_q.preCnt = 6'h00;
            next_q.fnCnt = stepTimes(q.stepTime, q.frameNo);
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
      q.st <= TXIR_IDLE;
      q.lfsr <= TXIR_LFSR_RESET;
      q.baseReload <= TXIR_BASE_RESET;
      q.stepTime <= TXIR_STEP_RESET;
      q.frameCount <= TXIR_FCNT_RESET;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign readData = q.rdata;
  assign txRequest = (q.st == TXIR_FRAME);
  assign oscPowerDown = q.interframe_powerdown && (q.st == TXIR_GAP);
  assign wakeMcu = q.doneFlag;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_lfsr_reset_seed: assert property ($past(reset) |-> q.lfsr == 7'h40)
    else $error("LFSR not seeded after reset");

  a_lfsr_step_once: assert property (
    intervalDone && !seedWr |=> q.lfsr == lfsrStep($past(q.lfsr)))
    else $error("LFSR not clocked once after interval");

  a_lfsr_stays_live: assert property (
    q.lfsr != 7'h00 && !seedWr |=> q.lfsr != 7'h00)
    else $error("LFSR fell into zero state");

  a_last_frame_done: assert property (
    q.st == TXIR_FRAME && frameDone &&
    q.frameNo == {1'b0, q.frameCount} + 5'h01
    |=> q.st == TXIR_IDLE && wakeMcu)
    else $error("Datagram did not end after last frame");

  a_frame_limit: assert property (
    q.frameNo <= {1'b0, q.frameCount} + 5'h01)
    else $error("Too many frames sent");

  a_gap_powerdown: assert property (
    q.st == TXIR_GAP && q.interframe_powerdown |-> oscPowerDown && !txRequest)
    else $error("Oscillator not powered down in gap");

  a_base_countdown: assert property (
    msTick && q.baseCnt != 8'h00 |=> q.baseCnt == $past(q.baseCnt) - 8'h01)
    else $error("Base counter did not decrement");

  a_parallel_count: assert property (
    msTick && q.parallel && q.baseCnt != 8'h00 && q.fnCnt != 10'h000
    |=> q.fnCnt == $past(q.fnCnt) - 10'h001)
    else $error("Step counter not running beside base");

  a_step_load: assert property (
    q.st == TXIR_FRAME && frameDone && next_q.st == TXIR_GAP
    |=> q.fnCnt == stepTimes($past(q.stepTime), $past(q.frameNo)))
    else $error("Frame-number time loaded wrongly");

  a_scale_load: assert property (
    q.st == TXIR_IDLE && sendWr && busReq.wdata[TXIR_ISCALE_BIT]
    |=> q.preCnt == 6'd39 && q.fnCnt == 10'h000)
    else $error("Initial scale not applied");

  a_tick_period: assert property (
    msTick |=> q.divCnt == 7'h00)
    else $error("Tick divider not restarted");

  ////////////////////////////////////////////////////////////////////////////
  // Interval and register checks

  a_rand_countdown: assert property (
    msTick && q.baseCnt == 8'h00 && q.randCnt != 7'h00 && q.preCnt == 6'h00
    |=> q.randCnt == $past(q.randCnt) - 7'h01)
    else $error("Random counter did not decrement");

  a_scale_prescale: assert property (
    msTick && q.baseCnt == 8'h00 && q.randCnt != 7'h00 && q.preCnt != 6'h00
    |=> q.preCnt == $past(q.preCnt) - 6'h01 && $stable(q.randCnt))
    else $error("Scale prescaler did not count");

  a_serial_step: assert property (
    msTick && q.baseCnt == 8'h00 && q.randCnt == 7'h00 && q.fnCnt != 10'h000
    |=> q.fnCnt == $past(q.fnCnt) - 10'h001)
    else $error("Step counter did not follow random part");

  a_init_load: assert property (
    q.st == TXIR_IDLE && sendWr
    |=> q.st == TXIR_INIT && q.baseCnt == $past(q.baseReload) &&
        q.randCnt == $past(q.lfsr) && q.fnCnt == 10'h000)
    else $error("Initial interval loaded wrongly");

  a_gap_load: assert property (
    q.st == TXIR_FRAME && frameDone && next_q.st == TXIR_GAP
    |=> q.baseCnt == $past(q.baseReload) && q.randCnt == $past(q.lfsr))
    else $error("Gap interval loaded wrongly");

  a_zero_rand_mode: assert property (
    q.st == TXIR_FRAME && frameDone && next_q.st == TXIR_GAP
    |=> q.parallel == ($past(q.lfsr) == 7'h00))
    else $error("Parallel mode chosen wrongly");

  a_frame_after_gap: assert property (
    intervalDone |=> txRequest && q.frameNo == $past(q.frameNo) + 5'h01)
    else $error("Frame not started after interval");

  a_frame_holds: assert property (
    q.st == TXIR_FRAME && !frameDone |=> txRequest)
    else $error("Frame request dropped early");

  a_idle_quiet: assert property (
    q.st == TXIR_IDLE |-> !txRequest && !oscPowerDown)
    else $error("Output active while idle");

  a_seed_write: assert property (
    seedWr |=> q.lfsr == $past(busReq.wdata[6:0]))
    else $error("Seed write lost");

  a_seed_read: assert property (
    busReq.rd && busReq.addr == TXIR_RANDOM_SEED_STATE
    |=> readData == {1'b0, $past(q.lfsr)})
    else $error("Seed read back wrongly");

  a_count_field: assert property (
    busReq.wr && busReq.addr == TXIR_FRAME_CONTROL_REG
    |=> q.frameCount == $past(busReq.wdata[3:0]))
    else $error("Frame count field not stored");

  a_step_field: assert property (
    busReq.wr && busReq.addr == TXIR_FRAME_STEP_SETTING
    |=> q.stepTime == $past(busReq.wdata[5:0]))
    else $error("Frame step field not stored");

  a_single_frame: assert property (
    q.st == TXIR_FRAME && frameDone && q.frameCount == 4'h0
    |=> q.st == TXIR_IDLE)
    else $error("Single frame datagram did not end");

  a_lfsr_hold: assert property (
    !intervalDone && !seedWr |=> $stable(q.lfsr))
    else $error("LFSR moved outside interval end");

  a_done_sticky: assert property (
    wakeMcu && !(busReq.wr && busReq.addr == TXIR_STATUS_REG &&
    busReq.wdata[TXIR_DONE_BIT]) |=> wakeMcu)
    else $error("Wake flag dropped without clear");

  a_done_clear: assert property (
    busReq.wr && busReq.addr == TXIR_STATUS_REG &&
    busReq.wdata[TXIR_DONE_BIT] && q.st != TXIR_FRAME |=> !wakeMcu)
    else $error("Wake flag not cleared");

  a_divider_idle: assert property (
    !running |=> q.divCnt == 7'h00)
    else $error("Tick divider ran outside interval");

  c_step_gap: cover property (q.st == TXIR_GAP && q.fnCnt != 10'h000 &&
                              msTick);
  c_datagram_done: cover property (q.st == TXIR_FRAME ##1 q.doneFlag);
  c_gap_entered: cover property (q.st == TXIR_FRAME ##1 q.st == TXIR_GAP);
  c_scaled_init: cover property (q.scaleAct && q.randCnt != 7'h00 &&
                                 msTick);
  c_parallel_gap: cover property (q.st == TXIR_GAP && q.parallel &&
                                  q.baseCnt != 8'h00);

endmodule
`default_nettype wire

// *** sim/txir_rf_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module txir_rf_model (
  input wire logic ref_clk,
  input wire logic txRequest,
  output logic midFreqOsc,
  output logic frameDone
);
  logic [1:0] ph = 2'h0;
  logic [2:0] cnt = 3'h0;
  logic [2:0] len = 3'h1;
  initial begin
    midFreqOsc = 1'b0;
    frameDone = 1'b0;
  end
  // Oscillator pulse every fourth clock, frame of random length
  always @(posedge ref_clk) begin
    ph <= ph + 2'h1;
    midFreqOsc <= (ph == 2'h2);
    frameDone <= 1'b0;
    if (!txRequest) begin
      cnt <= 3'h0;
      len <= 3'($urandom_range(1, 6));
    end else if (cnt == len) begin
      frameDone <= 1'b1;
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule
`default_nettype wire

// *** sim/txir_randomizer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module txir_randomizer_tb;
  import txir_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  txir_bus_req_t busReq = '0;
  logic [7:0] readData;
  logic midFreqOsc, frameDone, txRequest, oscPowerDown, wakeMcu;
  int err_count = 0;
  int checked = 0;
  int cnt = 0;
  logic [7:0] readQ[$];
  logic [16:0] intQ[$];
  logic [16:0] e;
  logic rdPrev = 1'b0;
  logic txPrev = 1'b0;
  logic pdPrev = 1'b0;

  txir_randomizer #(.MFO_DIV(2)) dut (.ref_clk, .reset, .busReq,
    .readData, .midFreqOsc, .frameDone, .txRequest, .oscPowerDown,
    .wakeMcu);
  txir_rf_model peer (.ref_clk, .txRequest, .midFreqOsc, .frameDone);

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [15:0] s, x);
    checked++;
    if (s !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(input logic [2:0] a, input logic [7:0] d, input logic w);
    @(posedge ref_clk);
    busReq <= '{a, d, w, !w};
    @(posedge ref_clk);
    busReq <= '0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] x);
    readQ.push_back(x);
    cyc(a, 8'h00, 1'b0);
  endtask

  function automatic logic [6:0] nx(input logic [6:0] l);
    return (l >> 1) ^ (l[0] ? 7'h60 : 7'h00);
  endfunction

  function automatic logic [15:0] tk(input logic [7:0] b, input logic [6:0] l,
      input logic [5:0] s, input int k, input logic sc);
    logic [15:0] f;
    f = 16'(s) * 16'(k);
    if (l == 7'h00) return (16'(b) > f) ? 16'(b) : f;
    return 16'(b) + f + 16'(l) * (sc ? 16'h0028 : 16'h0001);
  endfunction

  task automatic dg(input logic [3:0] fc, input logic pd, sc,
      input logic [7:0] b, input logic [5:0] s, input logic [6:0] l);
    int t;
    t = 100;
    cyc(TXIR_BASE_INTERVAL_RELOAD, b, 1'b1);
    cyc(TXIR_FRAME_STEP_SETTING, {2'h0, s}, 1'b1);
    cyc(TXIR_RANDOM_SEED_STATE, {1'h0, l}, 1'b1);
    for (int k = 0; k <= fc; k++) begin
      intQ.push_back({k > 0 && pd, tk(b, l, s, k, sc && k == 0)});
      t += int'(intQ[$][15:0]) * 8 + 20;
      l = nx(l);
    end
    cyc(TXIR_FRAME_CONTROL_REG, {2'h2, sc, pd, fc}, 1'b1);
    repeat (t) begin
      @(posedge ref_clk);
      if (wakeMcu === 1'b1) break;
    end
    check("wakeMcu", 16'(wakeMcu), 16'h0001);
    rd(TXIR_RANDOM_SEED_STATE, {1'h0, l});
    rd(TXIR_STATUS_REG, {5'(fc) + 5'h01, 3'h1});
    cyc(TXIR_STATUS_REG, 8'h01, 1'b1);
    @(negedge ref_clk);
    check("wakeClear", 16'(wakeMcu), 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Results: read data and interval lengths in ticks of eight clocks
  always @(posedge ref_clk) begin
    if (rdPrev) check("readData", 16'(readData), 16'(readQ.pop_front()));
    rdPrev = busReq.rd;
    cnt++;
    if (busReq.wr && busReq.addr == 3'h0 && busReq.wdata[7]) cnt = 0;
    if (txRequest && !txPrev) begin
      e = intQ.pop_front();
      check("ticks", 16'((cnt + 3) / 8), e[15:0]);
      check("powerDown", 16'(pdPrev), 16'(e[16]));
      check("earlyWake", 16'(wakeMcu), 16'h0000);
    end
    if (!txRequest && txPrev) cnt = 0;
    txPrev = txRequest;
    pdPrev = oscPowerDown;
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    conclude();
  end

  initial begin
    logic [2:0] wa [4];
    logic [7:0] wx [4];
    wa = '{3'h1, 3'h2, 3'h3, 3'h5};
    wx = '{8'hFF, 8'h7F, 8'h3F, 8'h00};
    void'($urandom(25469));
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a), a == 2 ? 8'h40 : 8'h00);
    foreach (wa[i]) begin
      cyc(wa[i], 8'hFF, 1'b1);
      rd(wa[i], wx[i]);
    end
    $display("test registers done");
    dg(4'h0, 1'b0, 1'b1, 8'h05, 6'h00, 7'h01);
    $display("test scaled initial done");
    dg(4'h2, 1'b1, 1'b0, 8'h06, 6'h04, 7'h00);
    $display("test parallel countdown done");
    dg(4'hF, 1'b0, 1'b0, 8'h00, 6'h01, 7'h03);
    $display("test sixteen frames done");
    repeat (5) begin
      dg(4'($urandom_range(1, 3)), 1'($urandom), 1'b0,
        $urandom_range(0, 1) ? 8'($urandom_range(5, 12)) : 8'h00,
        6'($urandom_range(0, 5)), 7'($urandom_range(1, 127)));
    end
    $display("test random datagrams done");
    conclude();
  end
endmodule
`default_nettype wire
